// *** vac_regs.vh ***
// Contract
// (R1) External clamp pin used when option set
// (R2) Placement counted from sync trailing edge
// (R3) Placement and duration are 8-bit pixel counts
// (R4) Software starts with placement 09h, duration 14h
// (R5) Clamp drives code 00h or 80h
// (R6) Per-channel clamp select in register 10h bits 0-2
// (R7) Three 8-bit gains; higher gain, less contrast
// (R8) Three 7-bit offsets, plus/minus 63 LSB
// (R9) Green embedded sync always negative-going
// (R10) Divide pixel clock, compare against line sync
// (R11) Divisor 221 to 4095, ratio is value plus one
// (R12) Band 00 is 12-36, 01 is 36-72 MHz
// (R13) Band 10 selects the highest region
// (R14) Three-bit loop current code, 50 to 1500 uA
// (R15) Five-bit phase, 32 steps of 11.25 degrees
// (R16) Sync output delayed by the same phase
// (R17) Coast ignores sync edges, keeps frequency
// (R18) Polarity bit 1 means active high
// (R19) External clamp enable 0Fh bit 7, reset 0
// (R20) Coast polarity 0Fh bit 3, reset 1
// (R21) Sync trailing edge restarts; exact duration
`ifndef VAC_REGS_VH
`define VAC_REGS_VH

`define VAC_A_REVISION 8'h00
`define VAC_A_DIV_HI 8'h01
`define VAC_A_DIV_LO 8'h02
`define VAC_A_PLL_CTL 8'h03
`define VAC_A_PHASE 8'h04
`define VAC_A_CLAMP_DLY 8'h05
`define VAC_A_CLAMP_LEN 8'h06
`define VAC_A_RED_GAIN 8'h08
`define VAC_A_GRN_GAIN 8'h09
`define VAC_A_BLU_GAIN 8'h0a
`define VAC_A_RED_OFS 8'h0b
`define VAC_A_GRN_OFS 8'h0c
`define VAC_A_BLU_OFS 8'h0d
`define VAC_A_SYNC_CTL 8'h0e
`define VAC_A_MODE 8'h0f
`define VAC_A_CLAMP_SEL 8'h10
`define VAC_A_STATUS 8'h11

`define VAC_B_EXT_CLAMP 7
`define VAC_B_CLAMP_POL 6
`define VAC_B_COAST_POL 3
`define VAC_B_HS_POL 7
`define VAC_B_SOG_SEL 6

`define VAC_RST_DIV 12'h69d
`define VAC_RST_BAND 2'h1
`define VAC_RST_PUMP 3'h4
`define VAC_RST_PHASE 5'h10
`define VAC_RST_CLAMP_DLY 8'h09
`define VAC_RST_CLAMP_LEN 8'h14
`define VAC_RST_GAIN 8'h80
`define VAC_RST_OFS 7'h40
`define VAC_RST_MODE 8'h08
`define VAC_RST_ZERO 8'h00

`define VAC_DIV_MIN 12'h0dd
`define VAC_CODE_MID 8'h80
`define VAC_CODE_GND 8'h00
`define VAC_PHASE_TAPS 32

`endif

// *** vac_clamp_gen.v ***
`timescale 1ns/1ps
`default_nettype none
`include "vac_regs.vh"
module vac_clamp_gen (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Timing inputs
    input wire sync_trail,
    input wire ext_enable,
    input wire ext_level,
    input wire [7:0] start_delay,
    input wire [7:0] length,
    // Clamp window
    output reg clamp
);

localparam ST_IDLE = 3'b001;
localparam ST_DELAY = 3'b010;
localparam ST_CLAMP = 3'b100;

reg [2:0] state;
reg [7:0] cnt;

always @(posedge clk) begin
    if (!reset_n) begin
        state <= ST_IDLE;
        cnt <= `VAC_RST_ZERO;
        clamp <= 1'b0;
    end else begin
        // A new trailing edge always restarts the placement count.
        if (sync_trail) begin
            state <= ST_DELAY; // (R21)
            cnt <= start_delay; // (R2) (R3)
        end else begin
            case (state)
                ST_IDLE: begin
                    cnt <= cnt;
                end
                ST_DELAY: begin
                    if (cnt == `VAC_RST_ZERO) begin
                        state <= (length == `VAC_RST_ZERO) ? ST_IDLE : ST_CLAMP; // (R2)
                        cnt <= length; // (R3)
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                ST_CLAMP: begin
                    if (cnt == 8'h01) begin
                        state <= ST_IDLE; // (R21)
                    end
                    cnt <= cnt - 8'h01;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
        // The pin path bypasses the counters entirely when enabled.
        clamp <= ext_enable ? ext_level : (state == ST_CLAMP); // (R1) (R19)
    end
end

endmodule
`default_nettype wire

// *** vac_front_ctl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "vac_regs.vh"
module vac_front_ctl #(
    parameter [6:0] DEV_ADDR = 7'h4c,
    // Arbitrary revision value.
    parameter [7:0] REVISION = 8'h00
) (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Two-wire serial port
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    // Sync and timing pins
    input wire hsync_in,
    input wire green_embedded_sync,
    input wire coast_in,
    input wire clamp_in,
    // Clamp control
    output wire clamp_active,
    output wire [23:0] clamp_code,
    // Gain and offset settings
    output reg [7:0] red_full_scale,
    output reg [7:0] green_full_scale,
    output reg [7:0] blue_full_scale,
    output reg [6:0] red_level_shift,
    output reg [6:0] green_level_shift,
    output reg [6:0] blue_level_shift,
    // Clock generator settings
    output wire osc_band_bit1,
    output wire osc_band_bit0,
    output wire loop_current_bit2,
    output wire loop_current_bit1,
    output wire loop_current_bit0,
    output reg [4:0] sample_phase_step,
    output reg [11:0] pll_ratio,
    output reg pll_feedback,
    output reg pll_speed_up,
    output reg pll_slow_down,
    // Aligned sync
    output reg line_sync_out
);

////////////////////////////////////////////////////////////////////////////////
// Register storage

reg [11:0] pll_feedback_divide;
reg [1:0] oscillator_band;
reg [2:0] loop_current_select;
reg [7:0] clamp_start_delay;
reg [7:0] clamp_length;
reg [7:0] sync_ctl;
reg [7:0] mode_ctl;
reg [2:0] clamp_select;

assign osc_band_bit1 = oscillator_band[1]; // (R12) (R13)
assign osc_band_bit0 = oscillator_band[0]; // (R12)
assign loop_current_bit2 = loop_current_select[2]; // (R14)
assign loop_current_bit1 = loop_current_select[1]; // (R14)
assign loop_current_bit0 = loop_current_select[0]; // (R14)

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg [4:0] pin_s1;
reg [4:0] pin_s2;
reg scl_d;
reg sda_d;

always @(posedge clk) begin
    if (!reset_n) begin
        // Idle levels keep the edge detectors quiet as reset ends.
        pin_s1 <= 5'h1c;
        pin_s2 <= 5'h1c;
        scl_d <= 1'b1;
        sda_d <= 1'b1;
    end else begin
        pin_s1 <= {scl_in, sda_in, green_embedded_sync, hsync_in, clamp_in};
        pin_s2 <= pin_s1;
        scl_d <= pin_s2[4];
        sda_d <= pin_s2[3];
    end
end

wire scl_s = pin_s2[4];
wire sda_s = pin_s2[3];
wire sog_s = pin_s2[2];
wire hs_s = pin_s2[1];
wire clamp_s = pin_s2[0];

// Coast is documented as asynchronous, so it gets its own pair.
reg coast_s1;
reg coast_s2;
always @(posedge clk) begin
    if (!reset_n) begin
        coast_s1 <= 1'b0;
        coast_s2 <= 1'b0;
    end else begin
        coast_s1 <= coast_in;
        coast_s2 <= coast_s1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Sync processing

wire hs_act = hs_s ~^ sync_ctl[`VAC_B_HS_POL]; // (R18)
wire sog_act = ~sog_s; // (R9)
wire sync_act = sync_ctl[`VAC_B_SOG_SEL] ? sog_act : hs_act;
wire coast_act = coast_s2 ~^ mode_ctl[`VAC_B_COAST_POL]; // (R17) (R18)
wire clamp_lvl = clamp_s ~^ mode_ctl[`VAC_B_CLAMP_POL]; // (R1)

reg sync_d;
always @(posedge clk) begin
    if (!reset_n) begin
        sync_d <= 1'b0;
    end else begin
        sync_d <= sync_act;
    end
end

wire sync_lead = sync_act & ~sync_d;
wire sync_trail = ~sync_act & sync_d;

vac_clamp_gen u_clamp (
    .clk(clk),
    .reset_n(reset_n),
    .sync_trail(sync_trail),
    .ext_enable(mode_ctl[`VAC_B_EXT_CLAMP]),
    .ext_level(clamp_lvl),
    .start_delay(clamp_start_delay),
    .length(clamp_length),
    .clamp(clamp_active)
);

genvar ch;
generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_target
        reg [7:0] code;
        always @(posedge clk) begin
            if (!reset_n) begin
                code <= `VAC_CODE_GND;
            end else begin
                code <= clamp_select[ch] ? `VAC_CODE_MID : `VAC_CODE_GND; // (R5) (R6)
            end
        end
        assign clamp_code[ch*8 +: 8] = code;
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Feedback divider and phase compare

reg [11:0] fb_cnt;
reg [31:0] sync_dly;
wire [11:0] div_eff = (pll_feedback_divide < `VAC_DIV_MIN) ? `VAC_DIV_MIN :
    pll_feedback_divide; // (R11)

always @(posedge clk) begin
    if (!reset_n) begin
        fb_cnt <= 12'h000;
        pll_ratio <= 12'h000;
        pll_feedback <= 1'b0;
        pll_speed_up <= 1'b0;
        pll_slow_down <= 1'b0;
        sync_dly <= 32'h00000000;
        line_sync_out <= 1'b0;
    end else begin
        // Counting 0..div gives a ratio of div plus one.
        fb_cnt <= (fb_cnt >= div_eff) ? 12'h000 : fb_cnt + 12'h001; // (R10) (R11)
        pll_ratio <= div_eff; // (R11)
        pll_feedback <= (fb_cnt == 12'h000);
        // Edges seen under coast are dropped so the loop holds its rate.
        pll_speed_up <= sync_lead & ~coast_act & (fb_cnt > {1'b0, div_eff[11:1]}); // (R10) (R17)
        pll_slow_down <= sync_lead & ~coast_act & (fb_cnt != 12'h000) &
            (fb_cnt <= {1'b0, div_eff[11:1]}); // (R10) (R17)
        // One tap per step stands in for the sub-cycle shift.
        sync_dly <= {sync_dly[30:0], sync_act};
        line_sync_out <= sync_dly[sample_phase_step]; // (R15) (R16)
    end
end

////////////////////////////////////////////////////////////////////////////////
// Two-wire serial slave

localparam SS_IDLE = 7'b0000001;
localparam SS_ADDR = 7'b0000010;
localparam SS_ACKA = 7'b0000100;
localparam SS_SUB = 7'b0001000;
localparam SS_WR = 7'b0010000;
localparam SS_RD = 7'b0100000;
localparam SS_RACK = 7'b1000000;

reg [6:0] ss;
reg [3:0] bit_cnt;
reg [7:0] shreg;
reg [7:0] ptr;
reg rw;
reg pull_low;
reg ack_pend;

wire scl_rise = scl_s & ~scl_d;
wire scl_fall = ~scl_s & scl_d;
wire start_cond = scl_s & scl_d & ~sda_s & sda_d;
wire stop_cond = scl_s & scl_d & sda_s & ~sda_d;

assign sda_out = 1'b0;
assign sda_oe_n = ~pull_low;

function [7:0] rd_mux;
    input [7:0] a;
    begin
        case (a)
            `VAC_A_REVISION: rd_mux = REVISION;
            `VAC_A_DIV_HI: rd_mux = pll_feedback_divide[11:4];
            `VAC_A_DIV_LO: rd_mux = {pll_feedback_divide[3:0], 4'h0};
            `VAC_A_PLL_CTL: rd_mux = {oscillator_band, loop_current_select, 3'h0};
            `VAC_A_PHASE: rd_mux = {sample_phase_step, 3'h0};
            `VAC_A_CLAMP_DLY: rd_mux = clamp_start_delay;
            `VAC_A_CLAMP_LEN: rd_mux = clamp_length;
            `VAC_A_RED_GAIN: rd_mux = red_full_scale;
            `VAC_A_GRN_GAIN: rd_mux = green_full_scale;
            `VAC_A_BLU_GAIN: rd_mux = blue_full_scale;
            `VAC_A_RED_OFS: rd_mux = {red_level_shift, 1'b0};
            `VAC_A_GRN_OFS: rd_mux = {green_level_shift, 1'b0};
            `VAC_A_BLU_OFS: rd_mux = {blue_level_shift, 1'b0};
            `VAC_A_SYNC_CTL: rd_mux = sync_ctl;
            `VAC_A_MODE: rd_mux = mode_ctl;
            `VAC_A_CLAMP_SEL: rd_mux = {5'h00, clamp_select};
            `VAC_A_STATUS: rd_mux = {5'h00, coast_act, sync_act, clamp_active};
            default: rd_mux = `VAC_RST_ZERO;
        endcase
    end
endfunction

always @(posedge clk) begin
    if (!reset_n) begin
        ss <= SS_IDLE;
        bit_cnt <= 4'h0;
        shreg <= `VAC_RST_ZERO;
        ptr <= `VAC_RST_ZERO;
        rw <= 1'b0;
        pull_low <= 1'b0;
        ack_pend <= 1'b0;
        pll_feedback_divide <= `VAC_RST_DIV;
        oscillator_band <= `VAC_RST_BAND;
        loop_current_select <= `VAC_RST_PUMP;
        sample_phase_step <= `VAC_RST_PHASE;
        clamp_start_delay <= `VAC_RST_CLAMP_DLY;
        clamp_length <= `VAC_RST_CLAMP_LEN;
        red_full_scale <= `VAC_RST_GAIN;
        green_full_scale <= `VAC_RST_GAIN;
        blue_full_scale <= `VAC_RST_GAIN;
        red_level_shift <= `VAC_RST_OFS;
        green_level_shift <= `VAC_RST_OFS;
        blue_level_shift <= `VAC_RST_OFS;
        sync_ctl <= `VAC_RST_GAIN;
        mode_ctl <= `VAC_RST_MODE; // (R19) (R20)
        clamp_select <= 3'h0;
    end else if (start_cond) begin
        ss <= SS_ADDR;
        bit_cnt <= 4'h0;
        pull_low <= 1'b0;
        ack_pend <= 1'b0;
    end else if (stop_cond) begin
        ss <= SS_IDLE;
        pull_low <= 1'b0;
        ack_pend <= 1'b0;
    end else if (scl_rise) begin
        if (ss == SS_RACK) begin
            // A high level here is a not-acknowledge: stop sending.
            ss <= sda_s ? SS_IDLE : SS_RACK;
        end else if (!ack_pend && (ss == SS_ADDR || ss == SS_SUB || ss == SS_WR)) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
        end
    end else if (scl_fall) begin
        if (ack_pend) begin
            ack_pend <= 1'b0;
            pull_low <= 1'b0;
            bit_cnt <= 4'h0;
            if (ss == SS_ACKA && rw) begin
                ss <= SS_RD;
                shreg <= rd_mux(ptr);
                pull_low <= (rd_mux(ptr) < 8'h80);
            end else if (ss == SS_ACKA) begin
                ss <= SS_SUB;
            end else if (ss == SS_SUB) begin
                ss <= SS_WR;
            end else begin
                ptr <= ptr + 8'h01;
            end
        end else begin
            case (ss)
                SS_ADDR: begin
                    if (bit_cnt == 4'h8) begin
                        if (shreg[7:1] == DEV_ADDR) begin
                            rw <= shreg[0];
                            ss <= SS_ACKA;
                            pull_low <= 1'b1;
                            ack_pend <= 1'b1;
                        end else begin
                            ss <= SS_IDLE;
                        end
                    end
                end
                SS_SUB: begin
                    if (bit_cnt == 4'h8) begin
                        ptr <= shreg;
                        pull_low <= 1'b1;
                        ack_pend <= 1'b1;
                    end
                end
                SS_WR: begin
                    if (bit_cnt == 4'h8) begin
                        pull_low <= 1'b1;
                        ack_pend <= 1'b1;
                        case (ptr)
                            `VAC_A_DIV_HI: pll_feedback_divide[11:4] <= shreg; // (R10)
                            `VAC_A_DIV_LO: pll_feedback_divide[3:0] <= shreg[7:4]; // (R10)
                            `VAC_A_PLL_CTL: begin
                                oscillator_band <= shreg[7:6]; // (R12) (R13)
                                loop_current_select <= shreg[5:3]; // (R14)
                            end
                            `VAC_A_PHASE: sample_phase_step <= shreg[7:3]; // (R15)
                            `VAC_A_CLAMP_DLY: clamp_start_delay <= shreg; // (R3)
                            `VAC_A_CLAMP_LEN: clamp_length <= shreg; // (R3)
                            `VAC_A_RED_GAIN: red_full_scale <= shreg; // (R7)
                            `VAC_A_GRN_GAIN: green_full_scale <= shreg; // (R7)
                            `VAC_A_BLU_GAIN: blue_full_scale <= shreg; // (R7)
                            `VAC_A_RED_OFS: red_level_shift <= shreg[7:1]; // (R8)
                            `VAC_A_GRN_OFS: green_level_shift <= shreg[7:1]; // (R8)
                            `VAC_A_BLU_OFS: blue_level_shift <= shreg[7:1]; // (R8)
                            `VAC_A_SYNC_CTL: sync_ctl <= shreg; // (R18)
                            `VAC_A_MODE: mode_ctl <= shreg; // (R19) (R20)
                            `VAC_A_CLAMP_SEL: clamp_select <= shreg[2:0]; // (R6)
                            default: ptr <= ptr;
                        endcase
                    end
                end
                SS_RD: begin
                    if (bit_cnt == 4'h7) begin
                        pull_low <= 1'b0;
                        ss <= SS_RACK;
                    end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        pull_low <= ~shreg[6];
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                SS_RACK: begin
                    ptr <= ptr + 8'h01;
                    shreg <= rd_mux(ptr + 8'h01);
                    pull_low <= (rd_mux(ptr + 8'h01) < 8'h80);
                    bit_cnt <= 4'h0;
                    ss <= SS_RD;
                end
                default: begin
                    pull_low <= 1'b0;
                end
            endcase
        end
    end
end

endmodule
`default_nettype wire

// *** vac_src_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module vac_src_model (
    // Clock and control
    input wire logic clk,
    input wire logic run,
    input wire logic active_high,
    // Sync lines
    output wire logic hsync,
    output wire logic green_sync
);
    logic [7:0] pos;
    wire logic pulse;
    initial pos = 8'h00;
    // A line is 200 pixels with a 16-pixel sync pulse; both lines stand idle when stopped.
    always @(posedge clk) begin
        pos <= #1 (pos == 8'hc7) ? 8'h00 : pos + 8'h01;
    end
    assign pulse = run && (pos < 8'h10);
    assign hsync = active_high ? pulse : !pulse;
    assign green_sync = !pulse;
endmodule
`default_nettype wire

// *** vac_front_ctl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module vac_front_ctl_props (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Watched pins
    input wire logic sda_oe_n,
    input wire logic coast_in,
    input wire logic clamp_active,
    input wire logic [23:0] clamp_code,
    input wire logic pll_feedback,
    input wire logic pll_speed_up,
    input wire logic pll_slow_down,
    input wire logic line_sync_out
);
    logic [15:0] fb_gap;
    logic fb_seen;
    logic [8:0] cl_run;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // The first divider pulse after reset has no pulse before it, so its gap is not judged.
    always @(posedge clk) begin
        if (!reset_n) begin
            fb_gap <= 16'h0000;
            fb_seen <= 1'b0;
            cl_run <= 9'h000;
        end else begin
            fb_gap <= pll_feedback ? 16'h0001 : fb_gap + 16'h0001;
            fb_seen <= fb_seen | pll_feedback;
            cl_run <= clamp_active ? cl_run + 9'h001 : 9'h000;
        end
    end
    ////////////////////////////////////////
    code_level_a: assert property (
        clamp_code[7:0] inside {8'h00, 8'h80} && clamp_code[15:8] inside {8'h00, 8'h80}
        && clamp_code[23:16] inside {8'h00, 8'h80}) else $error("bad clamp code");
    compare_excl_a: assert property (
        !(pll_speed_up && pll_slow_down)) else $error("both compare pulses");
    compare_pulse_a: assert property (
        $rose(pll_speed_up || pll_slow_down) |=> !(pll_speed_up || pll_slow_down))
        else $error("long compare pulse");
    divider_pulse_a: assert property (
        pll_feedback |=> !pll_feedback) else $error("long divider pulse");
    divider_gap_a: assert property (
        pll_feedback && fb_seen |-> fb_gap >= 16'h00de && fb_gap <= 16'h1000)
        else $error("divider period out of range");
    coast_hold_a: assert property (
        coast_in [*5] |-> !(pll_speed_up || pll_slow_down)) else $error("coast compare");
    clamp_length_a: assert property (
        cl_run <= 9'h0ff) else $error("clamp window too long");
    reset_quiet_a: assert property (disable iff (1'b0)
        !reset_n |=> sda_oe_n && !clamp_active && !line_sync_out) else $error("active in reset");
endmodule
bind vac_front_ctl vac_front_ctl_props u_props (.clk(clk), .reset_n(reset_n),
    .sda_oe_n(sda_oe_n), .coast_in(coast_in), .clamp_active(clamp_active),
    .clamp_code(clamp_code), .pll_feedback(pll_feedback), .pll_speed_up(pll_speed_up),
    .pll_slow_down(pll_slow_down), .line_sync_out(line_sync_out));
`default_nettype wire

// *** vac_front_ctl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "vac_regs.vh"
module vac_front_ctl_tb_top;
    localparam int H = 6;
    logic clk, reset_n, scl, sda_m, run, hs_pol, coast_in, clamp_in;
    wire logic hsync_in, green_sync, sda_w, sda_out, sda_oe_n, clamp_active;
    wire logic feedback, speed_up, slow_down, line_sync;
    wire logic [23:0] clamp_code;
    wire logic [7:0] gain [3];
    wire logic [6:0] ofs [3];
    wire logic [4:0] band_pump, phase;
    wire logic [11:0] ratio;
    int n_errors = 0;
    int num_checks = 0;
    // The serial data line has a pull-up, so it reads high unless someone pulls it low.
    assign sda_w = sda_m & (sda_oe_n | sda_out);
    vac_front_ctl uut (.clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .hsync_in(hsync_in),
        .green_embedded_sync(green_sync), .coast_in(coast_in), .clamp_in(clamp_in),
        .clamp_active(clamp_active), .clamp_code(clamp_code), .red_full_scale(gain[0]),
        .green_full_scale(gain[1]), .blue_full_scale(gain[2]), .red_level_shift(ofs[0]),
        .green_level_shift(ofs[1]), .blue_level_shift(ofs[2]), .osc_band_bit1(band_pump[4]),
        .osc_band_bit0(band_pump[3]), .loop_current_bit2(band_pump[2]),
        .loop_current_bit1(band_pump[1]), .loop_current_bit0(band_pump[0]),
        .sample_phase_step(phase), .pll_ratio(ratio), .pll_feedback(feedback),
        .pll_speed_up(speed_up), .pll_slow_down(slow_down), .line_sync_out(line_sync));
    vac_src_model src (.clk(clk), .run(run), .active_high(hs_pol), .hsync(hsync_in),
        .green_sync(green_sync));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    function automatic logic probe(input int sel);
        case (sel)
            0: return hsync_in;
            1: return clamp_active;
            2: return line_sync;
            3: return feedback;
            default: return green_sync;
        endcase
    endfunction
    task automatic await(input int sel, input logic v, output int n);
        n = 0;
        while (probe(sel) !== v) begin
            tick(1);
            n++;
            if (n > 5000) begin
                $display("mismatch wait%0d expected %b seen timeout", sel, v);
                n_errors++;
                give_verdict();
            end
        end
    endtask
    task automatic send_bit(input logic b);
        sda_m = b;
        tick(H);
        scl = 1'b1;
        tick(H);
        scl = 1'b0;
    endtask
    task automatic send_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i]);
        end
        sda_m = 1'b1;
        tick(H);
        scl = 1'b1;
        tick(H);
        chk("ack", 32'h0, sda_w);
        scl = 1'b0;
    endtask
    task automatic get_byte(output logic [7:0] d);
        sda_m = 1'b1;
        for (int i = 0; i < 8; i++) begin
            tick(H);
            scl = 1'b1;
            tick(H);
            d = {d[6:0], sda_w};
            scl = 1'b0;
        end
        send_bit(1'b1);
    endtask
    task automatic bus_start;
        sda_m = 1'b1;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_m = 1'b0;
        tick(H);
        scl = 1'b0;
    endtask
    task automatic bus_stop;
        sda_m = 1'b0;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_m = 1'b1;
        tick(H);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_start();
        send_byte(8'h98);
        send_byte(a);
        send_byte(d);
        bus_stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus_start();
        send_byte(8'h98);
        send_byte(a);
        bus_start();
        send_byte(8'h99);
        get_byte(d);
        bus_stop();
    endtask
    task automatic clamp_win(output int lat, output int dur);
        await(0, 1'b1, lat);
        await(0, 1'b0, lat);
        await(1, 1'b1, lat);
        await(1, 1'b0, dur);
    endtask
    task automatic ls_lat(input int src, input logic act, output int l);
        // Let the delay line drain so an older pulse is not taken for this one.
        tick(40);
        await(src, !act, l);
        await(src, act, l);
        await(2, 1'b1, l);
    endtask
    task automatic pulses(output int n);
        n = 0;
        tick(8);
        repeat (600) begin
            tick(1);
            if (speed_up === 1'b1 || slow_down === 1'b1) n++;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        logic [7:0] d;
        int l0, l1, l2, n;
        reset_n = 1'b0;
        scl = 1'b1;
        sda_m = 1'b1;
        run = 1'b0;
        hs_pol = 1'b1;
        coast_in = 1'b0;
        clamp_in = 1'b0;
        tick(10);
        reset_n = 1'b1;
        tick(3);
        rd(`VAC_A_MODE, d);
        chk("mode", `VAC_RST_MODE, d);
        done("reset");
        for (int i = 0; i < 6; i++) begin
            d = 8'h81 + 8'h22 * i[7:0];
            wr(`VAC_A_RED_GAIN + i[7:0], d);
            chk("gain_ofs", i < 3 ? d : d[7:1], i < 3 ? gain[i] : ofs[i - 3]);
        end
        for (int i = 0; i < 8; i++) begin
            d = {(i[1:0] == 2'h3 ? 2'h2 : i[1:0]), i[2:0], 3'h0};
            wr(`VAC_A_PLL_CTL, d);
            chk("band_pump", d[7:3], band_pump);
            wr(`VAC_A_CLAMP_SEL, i[7:0]);
            tick(4);
            chk("code", {i[2] ? 8'h80 : 8'h00, i[1] ? 8'h80 : 8'h00, i[0] ? 8'h80 : 8'h00},
                clamp_code);
        end
        done("settings");
        for (int i = 0; i < 6; i++) begin
            d = i < 2 ? 8'h88 : i < 4 ? 8'hc8 : 8'h08;
            if (i % 2 == 0) wr(`VAC_A_MODE, d);
            // Each mode is written while the pin already sits at the level the new setting treats as active.
            clamp_in = i[0] ^ i[1];
            tick(8);
            chk("ext_clamp", d[7] & (clamp_in == d[6]), clamp_active);
        end
        done("ext_clamp");
        run = 1'b1;
        wr(`VAC_A_CLAMP_DLY, 8'h09);
        wr(`VAC_A_CLAMP_LEN, 8'h14);
        clamp_win(l0, n);
        chk("clamp_len", 20, n);
        wr(`VAC_A_CLAMP_DLY, 8'h1e);
        wr(`VAC_A_CLAMP_LEN, 8'h01);
        clamp_win(l1, n);
        chk("clamp_len", 1, n);
        chk("clamp_start", 21, l1 - l0);
        done("int_clamp");
        coast_in = 1'b1;
        pulses(n);
        chk("coast_pulses", 0, n);
        coast_in = 1'b0;
        pulses(n);
        chk("sync_pulses", 1, n > 0);
        done("coast");
        wr(`VAC_A_PHASE, 8'h00);
        ls_lat(0, 1'b1, l0);
        wr(`VAC_A_PHASE, 8'hf8);
        chk("phase", 5'h1f, phase);
        ls_lat(0, 1'b1, l1);
        chk("sync_delay", 31, l1 - l0);
        hs_pol = 1'b0;
        wr(`VAC_A_SYNC_CTL, 8'h00);
        ls_lat(0, 1'b0, l2);
        chk("sync_low", l1, l2);
        wr(`VAC_A_SYNC_CTL, 8'h40);
        ls_lat(4, 1'b0, l2);
        chk("green_sync", l1, l2);
        done("phase_sync");
        for (int i = 0; i < 2; i++) begin
            wr(`VAC_A_DIV_HI, i == 0 ? 8'h0d : 8'hff);
            wr(`VAC_A_DIV_LO, i == 0 ? 8'hd0 : 8'hf0);
            repeat (2) begin
                await(3, 1'b1, n);
                tick(1);
            end
            await(3, 1'b1, n);
            chk("divide_period", i == 0 ? 222 : 4096, n + 1);
            chk("ratio", i == 0 ? 12'h0dd : 12'hfff, ratio);
        end
        done("divider");
        give_verdict();
    end
endmodule
`default_nettype wire
